// ===== inc/sbms_pkg.sv
package sbms_pkg;
    // APB register byte offsets
    localparam logic [7:0] SBMS_OFF_CTRL     = 8'h00;
    localparam logic [7:0] SBMS_OFF_FREQ     = 8'h04;
    localparam logic [7:0] SBMS_OFF_HOLD     = 8'h08;
    localparam logic [7:0] SBMS_OFF_VOLT     = 8'h0C;
    localparam logic [7:0] SBMS_OFF_MOTOR    = 8'h10;
    localparam logic [7:0] SBMS_OFF_TERM_LO  = 8'h14;
    localparam logic [7:0] SBMS_OFF_TERM_HI  = 8'h18;
    localparam logic [7:0] SBMS_OFF_GAIN     = 8'h1C;
    localparam logic [7:0] SBMS_OFF_STATUS   = 8'h20;
    // CTRL field positions
    localparam int SBMS_CTRL_METHOD_LSB = 0;
    localparam int SBMS_CTRL_MODE_LSB   = 2;
    localparam int SBMS_CTRL_PREX_BIT   = 4;
    localparam int SBMS_CTRL_SLB_BIT    = 5;
    localparam int SBMS_CTRL_TUNE_LSB   = 8;
    // Control methods
    localparam logic [1:0] SBMS_METH_VF   = 2'h0;
    localparam logic [1:0] SBMS_METH_AFV  = 2'h1;
    localparam logic [1:0] SBMS_METH_SLV  = 2'h2;
    localparam logic [1:0] SBMS_METH_VEC  = 2'h3;
    // Control modes
    localparam logic [1:0] SBMS_MODE_SPD  = 2'h0;
    localparam logic [1:0] SBMS_MODE_TRQ  = 2'h1;
    localparam logic [1:0] SBMS_MODE_POS  = 2'h2;
    // Special setting values; frequency in 0.01 Hz, time in 0.1 s, voltage in 0.1 %
    localparam logic [15:0] SBMS_FREQ_USE_START = 16'h270F;  // 9999
    localparam logic [15:0] SBMS_HOLD_EXTERNAL  = 16'h22B8;  // 8888
    localparam logic [15:0] SBMS_FREQ_DEF       = 16'h012C;  // 3.00 Hz
    localparam logic [15:0] SBMS_FREQ_DEF_VEC   = 16'h0032;  // 0.50 Hz
    localparam logic [15:0] SBMS_HOLD_DEF       = 16'h0005;  // 0.5 s
    localparam logic [15:0] SBMS_VOLT_4PCT      = 16'h0028;
    localparam logic [15:0] SBMS_VOLT_2PCT      = 16'h0014;
    localparam logic [15:0] SBMS_START_DEF      = 16'h0032;  // 0.50 Hz
    localparam logic [15:0] SBMS_GAIN_DEF       = 16'h0019;
    localparam logic [7:0]  SBMS_MOTOR_DEF      = 8'h00;
    localparam logic [7:0]  SBMS_FN_EXT_BRAKE   = 8'h0D;      // 13
    localparam logic [7:0]  SBMS_FN_PREEXCITE   = 8'h17;      // 23
    localparam logic [7:0]  SBMS_TUNE_OFFLINE1  = 8'h01;
    localparam logic [7:0]  SBMS_TUNE_OFFLINE2  = 8'h65;      // 101
    localparam int SBMS_NUM_TERMS    = 12;
    localparam int SBMS_NUM_LX_TERMS = 9;
    // Timing: 100 MHz clock, hold time unit 0.1 s
    localparam int SBMS_CLK_HZ       = 100_000_000;
    localparam int SBMS_TICK_MS      = 100;
    localparam int SBMS_TICK_CYCLES  = SBMS_CLK_HZ / 1000 * SBMS_TICK_MS;
    // Brake output kinds
    typedef enum logic [1:0] {
        SBMS_BRK_NONE  = 2'b00,
        SBMS_BRK_DC    = 2'b01,
        SBMS_BRK_ZERO  = 2'b10,
        SBMS_BRK_SERVO = 2'b11
    } sbms_brake_t;
    typedef enum logic [1:0] {
        SBMS_ST_IDLE  = 2'b00,
        SBMS_ST_TIMED = 2'b01,
        SBMS_ST_EXT   = 2'b10,
        SBMS_ST_DONE  = 2'b11
    } sbms_state_t;
endpackage

// ===== hdl/sbms_top.sv
`timescale 1ns/10ps
// Behaviour
// - Braking starts when output frequency falls to brake_start_frequency while decelerating.
// - Start frequency 9999 means use starting_frequency_setting instead.
// - Under vector control the reset default of start frequency is 0.5Hz.
// - Braking lasts brake_hold_time, counted from the start of braking.
// - Hold time 0 suppresses all stop braking; motor coasts.
// - Hold time 8888 brakes while external_brake_request is asserted.
// - External brake request is any terminal whose function is 13, of twelve.
// - External request with 8888 uses zero speed control under sensorless; V/F and advanced flux use DC injection.
// - DC voltage percent applies only to DC injection, not zero speed or servo.
// - Voltage percent 0 disables DC injection braking; motor coasts.
// - Voltage 4% becomes 2% on standard to constant-torque motor change.
// - Voltage 2% becomes 4% on constant-torque to standard motor change.
// - Sensorless with selection 1 uses zero speed control, 0 uses DC injection.
// - Sensorless selection 0 restart may be delayed about 2s by the loops.
// - Vector control outside position mode: hold selection 0 is zero speed, 1 is servo lock.
// - Zero speed control regulates speed to zero, no position loop.
// - Servo lock holds position using hold_position_gain.
// - V/F and advanced flux use DC injection; pre-excitation has no effect.
// - Pre-excitation request under sensorless or vector holds while stopped.
// - Pre-excitation request is any of the first nine terminals set to 23.
// - Offline tuning request during pre-excitation is skipped; motor starts.
module sbms_top
    import sbms_pkg::*;
#(
    parameter int TICK_CYCLES = SBMS_TICK_CYCLES,
    parameter bit VECTOR_DEFAULTS = 1'b0,
    parameter bit MID_CAPACITY = 1'b1
) (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic [15:0] OUT_FREQ_IN,
    input  wire logic        DECEL_IN,
    input  wire logic        STOPPED_IN,
    input  wire logic        START_CMD_IN,
    input  wire logic [11:0] TERMINAL_IN,
    output logic      [1:0]  BRAKE_KIND_OUT,
    output logic      [15:0] DC_VOLT_OUT,
    output logic      [15:0] POS_GAIN_OUT,
    output logic             DRIVE_RELEASE_OUT,
    output logic             TUNE_START_OUT,
    output logic             MOTOR_START_OUT
);
    typedef struct packed {
        logic [11:0] ctrl;
        logic [15:0] freq;
        logic [15:0] hold;
        logic [15:0] volt;
        logic [7:0]  motor;
        logic [47:0] term_lo;
        logic [47:0] term_hi;
        logic [15:0] gain;
        sbms_state_t st;
        logic [15:0] hold_cnt;
        logic [31:0] tick_cnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [1:0]  kind;
        logic [15:0] dc_volt;
        logic [15:0] pos_gain;
        logic        release_drv;
        logic        tune_start;
        logic        motor_start;
    } sbms_regs_t;

    sbms_regs_t r_q;
    sbms_regs_t r_d;

    logic [1:0]  method;
    logic [1:0]  mode;
    logic        prex_sel;
    logic        slb_sel;
    logic [7:0]  tune_sel;
    logic        ext_req;
    logic        lx_req;
    logic        lx_active;
    logic [15:0] trip_freq;
    logic        trip;
    logic        start_frq_wr;
    logic [15:0] start_freq;
    sbms_brake_t decel_kind;
    sbms_brake_t ext_kind;
    sbms_brake_t lx_kind;
    logic        wr_acc;
    logic        rd_acc;

    assign method   = r_q.ctrl[SBMS_CTRL_METHOD_LSB +: 2];
    assign mode     = r_q.ctrl[SBMS_CTRL_MODE_LSB +: 2];
    assign prex_sel = r_q.ctrl[SBMS_CTRL_PREX_BIT];
    assign slb_sel  = r_q.ctrl[SBMS_CTRL_SLB_BIT];
    assign tune_sel = {4'h0, r_q.ctrl[SBMS_CTRL_TUNE_LSB +: 4]} | {r_q.ctrl[11], 7'h00};
    assign start_freq = SBMS_START_DEF;
    assign start_frq_wr = 1'b0;
    assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN;
    assign rd_acc = PSEL_IN && !PENABLE_IN && !PWRITE_IN;

    function automatic logic std_motor(input logic [7:0] m);
        std_motor = (m == 8'h00) || (m >= 8'h02 && m <= 8'h08) || (m == 8'h14)
                 || (m == 8'h17) || (m == 8'h18) || (m == 8'h28) || (m == 8'h2B)
                 || (m == 8'h2C);
    endfunction

    function automatic logic ct_motor(input logic [7:0] m);
        ct_motor = (m == 8'h01) || (m >= 8'h0D && m <= 8'h12) || (m == 8'h32)
                || (m == 8'h35) || (m == 8'h36);
    endfunction

    // Terminal binding by function code
    always_comb begin
        ext_req = 1'b0;
        lx_req  = 1'b0;
        for (int i = 0; i < SBMS_NUM_TERMS; i++) begin
            logic [7:0] fn;
            fn = (i < 6) ? r_q.term_lo[i*8 +: 8] : r_q.term_hi[(i-6)*8 +: 8];
            if (TERMINAL_IN[i] && fn == SBMS_FN_EXT_BRAKE) begin
                ext_req = 1'b1;
            end
            if (TERMINAL_IN[i] && fn == SBMS_FN_PREEXCITE && i < SBMS_NUM_LX_TERMS) begin
                lx_req = 1'b1;
            end
        end
    end

    // Brake kind selection per control method
    always_comb begin
        decel_kind = SBMS_BRK_DC;
        lx_kind    = SBMS_BRK_NONE;
        ext_kind   = SBMS_BRK_DC;
        if (method == SBMS_METH_SLV) begin
            // DC choice leaves the loops a slow restart; zero speed restarts at once
            decel_kind = slb_sel ? SBMS_BRK_ZERO : SBMS_BRK_DC;
            lx_kind    = SBMS_BRK_ZERO;
            ext_kind   = SBMS_BRK_ZERO;
        end else if (method == SBMS_METH_VEC) begin
            decel_kind = prex_sel ? SBMS_BRK_SERVO : SBMS_BRK_ZERO;
            lx_kind    = prex_sel ? SBMS_BRK_SERVO : SBMS_BRK_ZERO;
            ext_kind   = prex_sel ? SBMS_BRK_SERVO : SBMS_BRK_ZERO;
            if (mode == SBMS_MODE_POS) begin
                decel_kind = SBMS_BRK_NONE;
                lx_kind    = SBMS_BRK_SERVO;
                ext_kind   = SBMS_BRK_NONE;
            end
        end
    end

    // Trip point: 9999 falls back to the starting frequency
    assign trip_freq = (r_q.freq == SBMS_FREQ_USE_START) ? start_freq : r_q.freq;
    assign trip = DECEL_IN && (OUT_FREQ_IN <= trip_freq);
    assign lx_active = lx_req && STOPPED_IN && (lx_kind != SBMS_BRK_NONE);

    always_comb begin
        r_d = r_q;
        r_d.pready      = 1'b0;
        r_d.pslverr     = 1'b0;
        r_d.tune_start  = 1'b0;
        r_d.motor_start = 1'b0;
        // APB: reads answer one cycle after setup, writes at access
        if (rd_acc || (PSEL_IN && !PENABLE_IN && PWRITE_IN)) begin
            r_d.pready = 1'b1;
            r_d.prdata = 32'h0000_0000;
            case (PADDR_IN)
                SBMS_OFF_CTRL:    r_d.prdata = {20'h0_0000, r_q.ctrl};
                SBMS_OFF_FREQ:    r_d.prdata = {16'h0000, r_q.freq};
                SBMS_OFF_HOLD:    r_d.prdata = {16'h0000, r_q.hold};
                SBMS_OFF_VOLT:    r_d.prdata = {16'h0000, r_q.volt};
                SBMS_OFF_MOTOR:   r_d.prdata = {24'h00_0000, r_q.motor};
                SBMS_OFF_TERM_LO: r_d.prdata = r_q.term_lo[31:0];
                SBMS_OFF_TERM_HI: r_d.prdata = r_q.term_hi[31:0];
                SBMS_OFF_GAIN:    r_d.prdata = {16'h0000, r_q.gain};
                SBMS_OFF_STATUS:  r_d.prdata = {24'h00_0000, ext_req, lx_req,
                                                r_q.release_drv, 1'b0, r_q.kind, r_q.st};
                default:          r_d.pslverr = 1'b1;
            endcase
        end
        if (wr_acc && r_q.pready && !r_q.pslverr) begin
            case (PADDR_IN)
                SBMS_OFF_CTRL: begin
                    r_d.ctrl = PWDATA_IN[11:0];
                    if (lx_active && (PWDATA_IN[15:8] == SBMS_TUNE_OFFLINE1
                                      || PWDATA_IN[15:8] == SBMS_TUNE_OFFLINE2)) begin
                        r_d.motor_start = 1'b1;
                    end else if (PWDATA_IN[15:8] == SBMS_TUNE_OFFLINE1
                                 || PWDATA_IN[15:8] == SBMS_TUNE_OFFLINE2) begin
                        r_d.tune_start = 1'b1;
                    end
                end
                SBMS_OFF_FREQ: r_d.freq = PWDATA_IN[15:0];
                SBMS_OFF_HOLD: r_d.hold = PWDATA_IN[15:0];
                SBMS_OFF_VOLT: r_d.volt = PWDATA_IN[15:0];
                SBMS_OFF_MOTOR: begin
                    r_d.motor = PWDATA_IN[7:0];
                    if (MID_CAPACITY && std_motor(r_q.motor) && ct_motor(PWDATA_IN[7:0])
                        && r_q.volt == SBMS_VOLT_4PCT) begin
                        r_d.volt = SBMS_VOLT_2PCT;
                    end else if (MID_CAPACITY && ct_motor(r_q.motor)
                                 && std_motor(PWDATA_IN[7:0]) && r_q.volt == SBMS_VOLT_2PCT) begin
                        r_d.volt = SBMS_VOLT_4PCT;
                    end
                end
                SBMS_OFF_TERM_LO: r_d.term_lo[31:0] = PWDATA_IN;
                SBMS_OFF_TERM_HI: r_d.term_hi[31:0] = PWDATA_IN;
                SBMS_OFF_GAIN: r_d.gain = PWDATA_IN[15:0];
                default: r_d.gain = r_q.gain;
            endcase
        end
        // Hold time base tick
        if (r_q.st == SBMS_ST_TIMED) begin
            if (r_q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
                r_d.tick_cnt = 32'h0000_0000;
                r_d.hold_cnt = r_q.hold_cnt + 16'h0001;
            end else begin
                r_d.tick_cnt = r_q.tick_cnt + 32'h0000_0001;
            end
        end
        case (r_q.st)
            SBMS_ST_IDLE: begin
                r_d.kind        = SBMS_BRK_NONE;
                r_d.release_drv = 1'b0;
                r_d.tick_cnt    = 32'h0000_0000;
                r_d.hold_cnt    = 16'h0000;
                if (r_q.hold == SBMS_HOLD_EXTERNAL) begin
                    if (ext_req) begin
                        r_d.st = SBMS_ST_EXT;
                    end
                end else if (trip && r_q.hold == 16'h0000) begin
                    r_d.st = SBMS_ST_DONE;
                end else if (trip) begin
                    r_d.st = SBMS_ST_TIMED;
                end
                if (lx_active) begin
                    r_d.kind = lx_kind;
                end
            end
            SBMS_ST_TIMED: begin
                r_d.kind = decel_kind;
                if (decel_kind == SBMS_BRK_DC && r_q.volt == 16'h0000) begin
                    r_d.kind = SBMS_BRK_NONE;
                end
                if (r_q.hold_cnt >= r_q.hold) begin
                    r_d.st   = SBMS_ST_DONE;
                    r_d.kind = SBMS_BRK_NONE;
                end
            end
            SBMS_ST_EXT: begin
                r_d.kind = ext_kind;
                if (ext_kind == SBMS_BRK_DC && r_q.volt == 16'h0000) begin
                    r_d.kind = SBMS_BRK_NONE;
                end
                if (!ext_req) begin
                    r_d.st   = SBMS_ST_IDLE;
                    r_d.kind = SBMS_BRK_NONE;
                end
            end
            SBMS_ST_DONE: begin
                r_d.kind        = SBMS_BRK_NONE;
                r_d.release_drv = 1'b1;
                if (lx_active) begin
                    r_d.kind = lx_kind;
                end
                if (START_CMD_IN || !DECEL_IN && !STOPPED_IN) begin
                    r_d.st = SBMS_ST_IDLE;
                end
            end
            default: r_d.st = SBMS_ST_IDLE;
        endcase
        // Voltage only matters for DC injection
        r_d.dc_volt = (r_d.kind == SBMS_BRK_DC) ? r_q.volt : 16'h0000;
        // Next gain, so a gain write during servo lock shows at once
        r_d.pos_gain = (r_d.kind == SBMS_BRK_SERVO) ? r_d.gain : 16'h0000;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            r_q          <= '0;
            r_q.freq     <= VECTOR_DEFAULTS ? SBMS_FREQ_DEF_VEC : SBMS_FREQ_DEF;
            r_q.hold     <= SBMS_HOLD_DEF;
            r_q.volt     <= SBMS_VOLT_4PCT;
            r_q.motor    <= SBMS_MOTOR_DEF;
            r_q.gain     <= SBMS_GAIN_DEF;
            r_q.st       <= SBMS_ST_IDLE;
            if (VECTOR_DEFAULTS) begin
                r_q.ctrl[1:0] <= SBMS_METH_VEC;
            end
        end else begin
            r_q <= r_d;
        end
    end

    // Zero speed carries no gain; servo lock hands the position loop its gain
    assign POS_GAIN_OUT      = r_q.pos_gain;

    assign PRDATA_OUT        = r_q.prdata;
    assign PREADY_OUT        = r_q.pready;
    assign PSLVERR_OUT       = r_q.pslverr;
    assign BRAKE_KIND_OUT    = r_q.kind;
    assign DC_VOLT_OUT       = r_q.dc_volt;
    assign DRIVE_RELEASE_OUT = r_q.release_drv;
    assign TUNE_START_OUT    = r_q.tune_start;
    assign MOTOR_START_OUT   = r_q.motor_start;

    a_hold_zero_coast: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (r_q.st == SBMS_ST_IDLE && trip && r_q.hold == 16'h0000)
        |=> r_q.st == SBMS_ST_DONE)
        else $error("Zero hold time did not coast");
    a_ext_zero_speed: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (r_q.st == SBMS_ST_EXT && method == SBMS_METH_SLV && ext_req && r_q.volt != 16'h0000)
        |=> BRAKE_KIND_OUT == SBMS_BRK_ZERO)
        else $error("External request not zero speed");
    a_volt_only_dc: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (BRAKE_KIND_OUT != SBMS_BRK_DC) |-> DC_VOLT_OUT == 16'h0000)
        else $error("Voltage driven outside DC braking");
    a_servo_gain: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (BRAKE_KIND_OUT == SBMS_BRK_SERVO) |-> POS_GAIN_OUT == r_q.gain)
        else $error("Servo lock without gain");
    a_vf_no_prex: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (method == SBMS_METH_VF || method == SBMS_METH_AFV) |->
        BRAKE_KIND_OUT != SBMS_BRK_ZERO && BRAKE_KIND_OUT != SBMS_BRK_SERVO)
        else $error("Pre-excitation under V/F");
    a_start_trip: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (r_q.st == SBMS_ST_IDLE && trip && r_q.hold != 16'h0000
         && r_q.hold != SBMS_HOLD_EXTERNAL) |=> r_q.st == SBMS_ST_TIMED)
        else $error("Braking did not start at trip");
    a_timed_end: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (r_q.st == SBMS_ST_TIMED && r_q.hold_cnt >= r_q.hold)
        |=> r_q.st == SBMS_ST_DONE ##1 DRIVE_RELEASE_OUT)
        else $error("Timed hold did not release");
    a_volt_swap: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (wr_acc && r_q.pready && PADDR_IN == SBMS_OFF_MOTOR && std_motor(r_q.motor)
         && ct_motor(PWDATA_IN[7:0]) && r_q.volt == SBMS_VOLT_4PCT && MID_CAPACITY)
        |=> r_q.volt == SBMS_VOLT_2PCT)
        else $error("Voltage not lowered to 2 percent");
endmodule // sbms_top

// ===== test/sbms_motor_model.sv
`timescale 1ns/10ps
// Drive loops: on request, ramp the output frequency from 10.00 Hz down to standstill
module sbms_motor_model (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        go_in,
    output logic      [15:0] freq_out,
    output logic             decel_out,
    output logic             stopped_out
);
    // Steps of 0.10 Hz, so every start threshold under test is met exactly
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            freq_out  <= 16'h0000;
            decel_out <= 1'b0;
        end else if (go_in) begin
            freq_out  <= 16'h03E8;
            decel_out <= 1'b1;
        end else if (freq_out > 16'h000A) begin
            freq_out  <= freq_out - 16'h000A;
        end else begin
            freq_out  <= 16'h0000;
            decel_out <= 1'b0;
        end
    end
    assign stopped_out = (freq_out == 16'h0000) && !decel_out;
endmodule // sbms_motor_model

// ===== test/tb.sv
`timescale 1ns/10ps
module tb
    import sbms_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [11:0] term = 12'h000;
    logic        go = 1'b0;
    logic        start = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] freq;
    logic        decel;
    logic        stopped;
    logic [1:0]  kind;
    logic [15:0] dcv;
    logic [15:0] gain;
    logic        rel;
    logic        tune;
    logic        mstart;
    int          miscompares = 0;
    int          check_count = 0;
    logic [7:0]  t_ctrl [8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h02, 8'h26, 8'h03, 8'h13};
    logic [1:0]  t_kind [8] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3};

    always #5 clk = ~clk;

    sbms_top #(
        .TICK_CYCLES (4)
    ) sbms_top_i (
        .SYS_CLK_IN        (clk),
        .RST_IN            (rst),
        .PADDR_IN          (paddr),
        .PSEL_IN           (psel),
        .PENABLE_IN        (penable),
        .PWRITE_IN         (pwrite),
        .PWDATA_IN         (pwdata),
        .PRDATA_OUT        (prdata),
        .PREADY_OUT        (pready),
        .PSLVERR_OUT       (pslverr),
        .OUT_FREQ_IN       (freq),
        .DECEL_IN          (decel),
        .STOPPED_IN        (stopped),
        .START_CMD_IN      (start),
        .TERMINAL_IN       (term),
        .BRAKE_KIND_OUT    (kind),
        .DC_VOLT_OUT       (dcv),
        .POS_GAIN_OUT      (gain),
        .DRIVE_RELEASE_OUT (rel),
        .TUNE_START_OUT    (tune),
        .MOTOR_START_OUT   (mstart)
    );

    sbms_motor_model sbms_motor_model_i (
        .clk_in      (clk),
        .rst_in      (rst),
        .go_in       (go),
        .freq_out    (freq),
        .decel_out   (decel),
        .stopped_out (stopped)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk(32'(n < 16), 32'h0000_0001);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk(32'(e), 32'(a > SBMS_OFF_STATUS));
    endtask

    // Full reset between cases, so no brake state leaks from one case into the next
    task automatic do_reset();
        rst  <= 1'b1;
        term <= 12'h000;
        repeat (3) @(posedge clk);
        rst  <= 1'b0;
    endtask

    task automatic cfg(input logic [15:0] c, f, h, v);
        wr(SBMS_OFF_CTRL, 32'(c));
        wr(SBMS_OFF_FREQ, 32'(f));
        wr(SBMS_OFF_HOLD, 32'(h));
        wr(SBMS_OFF_VOLT, 32'(v));
    endtask

    task automatic run_stop();
        int n;
        n = 0;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (kind === SBMS_BRK_NONE && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic stop_trial(input int i);
        logic [15:0] f;
        logic [15:0] thr;
        logic [15:0] v;
        int          len;
        f   = (i == 1) ? SBMS_FREQ_USE_START : ((i == 5) ? SBMS_START_DEF : SBMS_FREQ_DEF);
        thr = (i == 1) ? SBMS_START_DEF : f;
        v   = (i == 3) ? 16'h0000 : SBMS_VOLT_4PCT;
        len = 0;
        do_reset();
        cfg(16'(t_ctrl[i]), f, (i == 2) ? 16'h0000 : SBMS_HOLD_DEF, v);
        run_stop();
        chk(32'(kind), 32'(t_kind[i]));
        if (t_kind[i] != SBMS_BRK_NONE) begin
            chk(32'(freq <= thr && freq + 16'h003C > thr), 32'h0000_0001);
            chk(32'(dcv), (t_kind[i] == SBMS_BRK_DC) ? 32'(v) : 32'h0000_0000);
            chk(32'(gain), (t_kind[i] == SBMS_BRK_SERVO) ? 32'(SBMS_GAIN_DEF) : 32'h0);
            while (kind === t_kind[i] && len < 200) begin
                @(posedge clk);
                len++;
            end
            chk(32'(len >= 19 && len <= 22), 32'h0000_0001);
            repeat (2) @(posedge clk);
        end
        chk(32'(rel), 32'h0000_0001);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(rel), 32'h0000_0000);
    endtask

    task automatic tune_check(input logic [15:0] c, input logic t, input logic m);
        int nt;
        int nm;
        nt = 0;
        nm = 0;
        wr(SBMS_OFF_CTRL, 32'(c));
        repeat (6) begin
            @(posedge clk);
            nt += int'(tune === 1'b1);
            nm += int'(mstart === 1'b1);
        end
        chk(32'(nt), 32'(t));
        chk(32'(nm), 32'(m));
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        rdc(SBMS_OFF_FREQ, 32'(SBMS_FREQ_DEF));
        rdc(SBMS_OFF_HOLD, 32'(SBMS_HOLD_DEF));
        rdc(SBMS_OFF_GAIN, 32'(SBMS_GAIN_DEF));
        rdc(8'h24, 32'h0000_0000);
        wr(SBMS_OFF_MOTOR, 32'h0000_0001);
        rdc(SBMS_OFF_VOLT, 32'(SBMS_VOLT_2PCT));
        wr(SBMS_OFF_MOTOR, 32'h0000_0000);
        rdc(SBMS_OFF_VOLT, 32'(SBMS_VOLT_4PCT));
        // Row 5 keeps the start threshold at 0.50 Hz for zero speed braking
        for (int i = 0; i < 8; i++) begin
            stop_trial(i);
        end
        do_reset();
        cfg(16'h0002, SBMS_FREQ_DEF, SBMS_HOLD_EXTERNAL, SBMS_VOLT_4PCT);
        wr(SBMS_OFF_TERM_LO, 32'h000D_0000);
        term <= 12'h004;
        run_stop();
        chk(32'(kind), 32'(SBMS_BRK_ZERO));
        chk(32'(dcv), 32'h0000_0000);
        repeat (40) @(posedge clk);
        chk(32'(kind), 32'(SBMS_BRK_ZERO));
        term <= 12'h000;
        repeat (5) @(posedge clk);
        chk(32'(kind), 32'(SBMS_BRK_NONE));
        do_reset();
        cfg(16'h0013, SBMS_FREQ_DEF, SBMS_HOLD_DEF, SBMS_VOLT_4PCT);
        wr(SBMS_OFF_TERM_LO, 32'h0000_0017);
        term <= 12'h001;
        repeat (6) @(posedge clk);
        chk(32'(kind), 32'(SBMS_BRK_SERVO));
        chk(32'(gain), 32'(SBMS_GAIN_DEF));
        tune_check(16'h0113, 1'b0, 1'b1);
        term <= 12'h000;
        repeat (6) @(posedge clk);
        chk(32'(kind), 32'(SBMS_BRK_NONE));
        tune_check(16'h6513, 1'b1, 1'b0);
        wr(SBMS_OFF_CTRL, 32'h0000_0010);
        term <= 12'h001;
        repeat (6) @(posedge clk);
        chk(32'(kind), 32'(SBMS_BRK_NONE));
        report_and_stop();
    end

    // About 1,400 cycles are needed; 10,000 leaves ample margin
    initial begin
        #100_000;
        chk(32'h0000_0000, 32'h0000_0001);
        report_and_stop();
    end
endmodule // tb
